// ### common/gpc_defs.vh
// Constants for the general-purpose pin configuration block
// Notes on behaviour
// (RQ1) Bit 0 one is input, zero drives output
// (RQ2) Bit 1 one inverts the pin value
// (RQ3) Bit 7 one open drain, zero push-pull
// (RQ4) Group 1 bit 2 joins combined interrupt 1
// (RQ5) Groups 5/6 bit 5 joins combined interrupt 2
// (RQ6) Pin 1.5 bit 3 drives infrared transmit
// (RQ7) Pin 1.6 bit 3 drives floppy motor-on
// (RQ8) Pin 1.7 bit 3 drives floppy drive-select
// (RQ9) Pin 5.0 field: clock, irq14, gpio
// (RQ10) Pin 5.2 field: density, gpio, irq8, smi
// (RQ11) Pin 5.3 field: rom select, irq11, gpio, edge3
// (RQ12) Pin 5.4 field: rom enable, irq12, gpio, edge4
// (RQ13) Pin 6.0 field: rom data0, irq1, gpio, smi
// (RQ14) Pin 6.1 field: rom data1, irq3, gpio, led
// (RQ15) Pin 6.2 field: rom data2, irq4, gpio, ring
// (RQ16) Pin 6.3 field: rom data3, irq5, gpio, watchdog
// (RQ17) Combined interrupt routed by four-bit map field
// (RQ18) Combined interrupt debounce selectable per interrupt
// (RQ19) Reserved bits read zero, ignore writes
// (RQ20) Combined interrupt: enabled input pin active level
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH
// Register offsets
`define GPC_OFS_P15 8'he5
`define GPC_OFS_P16 8'he6
`define GPC_OFS_P17 8'he7
`define GPC_OFS_P50 8'hc8
`define GPC_OFS_P52 8'hca
`define GPC_OFS_P53 8'hcb
`define GPC_OFS_P54 8'hcc
`define GPC_OFS_P60 8'hd0
`define GPC_OFS_P61 8'hd1
`define GPC_OFS_P62 8'hd2
`define GPC_OFS_P63 8'hd3
`define GPC_OFS_CMB2 8'hef
`define GPC_OFS_CMB1 8'hf0
`define GPC_OFS_DATA_LO 8'hf8
`define GPC_OFS_DATA_HI 8'hf9
// Reset values
`define GPC_RST_CFG 8'h01
`define GPC_RST_P52 8'h09
`define GPC_RST_CMB 8'h00
`define GPC_RST_DATA 11'h000
// Writable masks, reserved bits held at zero
`define GPC_MASK_G1 8'h8f
`define GPC_MASK_G56 8'hbb
`define GPC_MASK_CMB 8'hf8
// Field positions
`define GPC_BIT_DIR 0
`define GPC_BIT_POL 1
`define GPC_BIT_EN1 2
`define GPC_BIT_FN1 3
`define GPC_FN_LSB 3
`define GPC_FN_MSB 4
`define GPC_BIT_EN2 5
`define GPC_BIT_OD 7
`define GPC_BIT_FILT 3
`define GPC_MAP_LSB 4
`define GPC_MAP_MSB 7
// Function field codes
`define GPC_FN_00 2'h0
`define GPC_FN_01 2'h1
`define GPC_FN_10 2'h2
`define GPC_FN_11 2'h3
// Combined map codes without a route
`define GPC_MAP_OFF 4'h0
`define GPC_MAP_BAD 4'h2
// Host interrupt numbers of pin functions
`define GPC_IRQ_P50 4'he
`define GPC_IRQ_P52 4'h8
`define GPC_IRQ_P53 4'hb
`define GPC_IRQ_P54 4'hc
`define GPC_IRQ_P60 4'h1
`define GPC_IRQ_P61 4'h3
`define GPC_IRQ_P62 4'h4
`define GPC_IRQ_P63 4'h5
// Timing
`define GPC_CLK_KHZ 40000
`define GPC_DEBOUNCE_US 1000
`endif

// ### hw/gpc_debounce.v
// Stability filter: output follows input once steady long enough
`timescale 1ns/1ps
module gpc_debounce #(
	parameter CYCLES = 40000,
	parameter CW = 16
) (
	input wire clk,
	input wire sys_rst,
	input wire din,
	output reg dout_q
);
	reg [CW-1:0] cnt_q; // Cycles the input has differed

	// Any bounce back restarts the count, so short glitches vanish
	always @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= {CW{1'b0}};
			dout_q <= 1'b0;
		end else if (din == dout_q) begin
			cnt_q <= {CW{1'b0}};
		end else if (cnt_q >= CYCLES[CW-1:0] - 1'b1) begin
			cnt_q <= {CW{1'b0}};
			dout_q <= din; // [RQ18]
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule // gpc_debounce

// ### hw/gpc_pin_cell.v
// One pad driver with direction, polarity and driver type
`timescale 1ns/1ps
`include "gpc_defs.vh"
module gpc_pin_cell (
	input wire clk,
	input wire sys_rst,
	input wire [7:0] cfg,
	input wire gpio_mode,
	input wire gpio_val,
	input wire alt_drv,
	input wire alt_val,
	input wire pad_sync,
	output reg pad_out_q,
	output reg pad_oe_n_q,
	output wire level
);
	wire drv; // Pin wants to drive
	wire val; // Value to put out
	wire od; // Open-drain select

	// Direction from bit 0 only in plain pin mode
	assign drv = gpio_mode ? ~cfg[`GPC_BIT_DIR] : alt_drv; // [RQ1]
	// On the output side, polarity applies to the plain pin value only
	assign val = gpio_mode ? (gpio_val ^ cfg[`GPC_BIT_POL]) : alt_val; // [RQ2]
	assign od = cfg[`GPC_BIT_OD];
	// Pin level as seen by software, after inversion
	assign level = pad_sync ^ cfg[`GPC_BIT_POL]; // [RQ2]

	// Open drain pulls low only, floats for a one
	always @(posedge clk) begin
		if (sys_rst) begin
			pad_out_q <= 1'b1;
			pad_oe_n_q <= 1'b1;
		end else begin
			pad_out_q <= od ? 1'b0 : val; // [RQ3]
			pad_oe_n_q <= ~(drv & (~od | ~val)); // [RQ3]
		end
	end
endmodule // gpc_pin_cell

// ### hw/gpc_pin_config_mux.v
// Pin configuration registers, function multiplexing and combined irqs
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "gpc_defs.vh"
module gpc_pin_config_mux #(
	parameter NPIN = 11,
	parameter DEBOUNCE_CYC = `GPC_DEBOUNCE_US * `GPC_CLK_KHZ / 1000
) (
	input wire clk,
	input wire sys_rst,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	// Pads: 1.5,1.6,1.7,5.0,5.2,5.3,5.4,6.0,6.1,6.2,6.3
	input wire [10:0] pad_in,
	output wire [10:0] pad_out,
	output wire [10:0] pad_oe_n,
	// Alternate output sources from other blocks
	input wire infrared_transmit_port2,
	input wire floppy_motor_on_drive1_n,
	input wire floppy_drive_select1_n,
	input wire drive_density_out1,
	input wire boot_rom_chip_select_n,
	input wire boot_rom_output_enable_n,
	input wire system_mgmt_interrupt_n,
	input wire led_drive,
	input wire watchdog_timeout_out,
	input wire [3:0] rom_data_out,
	input wire rom_data_drive,
	// Alternate inputs toward other blocks
	output reg pci_clock_q,
	output reg ring_indicate_n_q,
	output reg [3:0] rom_data_in_q,
	output reg [1:0] edge_int_q,
	// Host interrupt lines, one-hot per number
	output reg [15:0] host_irq_q
);
	// Pin indices
	localparam [3:0] P15 = 4'h0;
	localparam [3:0] P16 = 4'h1;
	localparam [3:0] P17 = 4'h2;
	localparam [3:0] P50 = 4'h3;
	localparam [3:0] P52 = 4'h4;
	localparam [3:0] P53 = 4'h5;
	localparam [3:0] P54 = 4'h6;
	localparam [3:0] P60 = 4'h7;
	localparam [3:0] P61 = 4'h8;
	localparam [3:0] P62 = 4'h9;
	localparam [3:0] P63 = 4'ha;

	reg [10:0] sync1_q; // First synchroniser stage
	reg [10:0] sync2_q; // Second stage, safe to use
	reg [10:0] prev_q; // Last sample for edge detect
	reg [7:0] cfg_q [0:10]; // Per-pin configuration
	reg [7:0] cmb1_q; // Combined interrupt 1 control
	reg [7:0] cmb2_q; // Combined interrupt 2 control
	reg [10:0] data_q; // Output values in plain pin mode
	reg hit; // Address names a pin register
	reg [3:0] idx; // Which pin register
	reg [10:0] gpio_m; // Pin is in plain mode
	reg [10:0] alt_drv; // Alternate function drives pin
	reg [10:0] alt_val; // Alternate drive value
	wire [10:0] level; // Inverted-as-configured pin level
	reg [10:0] en1; // Pin contributes to combined 1
	reg [10:0] en2; // Pin contributes to combined 2
	wire [10:0] dir_in; // Direction bit of each pin, one is input
	wire cmb1_raw; // Unfiltered combined 1
	wire cmb2_raw; // Unfiltered combined 2
	wire cmb1_flt; // Debounced combined 1
	wire cmb2_flt; // Debounced combined 2
	wire cmb1; // Combined 1 after filter select
	wire cmb2; // Combined 2 after filter select
	reg [15:0] irq_d; // Next host interrupt lines
	reg [7:0] rdata_d; // Next read data
	integer i, j, m;

	// Reset value of each pin register
	function [7:0] rst_val;
		input [3:0] k;
		begin
			rst_val = (k == P52) ? `GPC_RST_P52 : `GPC_RST_CFG;
		end
	endfunction

	// Writable bits; group 1 and groups 5/6 reserve different bits
	function [7:0] wr_mask;
		input [3:0] k;
		begin
			wr_mask = (k <= P17) ? `GPC_MASK_G1 : `GPC_MASK_G56;
		end
	endfunction

	// One-hot line for a map code; disable and invalid route nowhere
	function [15:0] route;
		input [3:0] map;
		begin
			if (map == `GPC_MAP_OFF || map == `GPC_MAP_BAD)
				route = 16'h0000; // [RQ17]
			else
				route = 16'h0001 << map; // [RQ17]
		end
	endfunction

	// Function field of a group 5/6 pin
	function [1:0] fsel;
		input [7:0] c;
		begin
			fsel = c[`GPC_FN_MSB:`GPC_FN_LSB];
		end
	endfunction

	// Two flops on every pad before any logic looks
	always @(posedge clk) begin
		if (sys_rst) begin
			sync1_q <= 11'h7ff;
			sync2_q <= 11'h7ff;
			prev_q <= 11'h7ff;
		end else begin
			sync1_q <= pad_in;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Address decode to a pin register index
	always @* begin
		hit = 1'b1;
		idx = 4'h0;
		if (reg_addr == `GPC_OFS_P15)
			idx = P15;
		else if (reg_addr == `GPC_OFS_P16)
			idx = P16;
		else if (reg_addr == `GPC_OFS_P17)
			idx = P17;
		else if (reg_addr == `GPC_OFS_P50)
			idx = P50;
		else if (reg_addr == `GPC_OFS_P52)
			idx = P52;
		else if (reg_addr == `GPC_OFS_P53)
			idx = P53;
		else if (reg_addr == `GPC_OFS_P54)
			idx = P54;
		else if (reg_addr == `GPC_OFS_P60)
			idx = P60;
		else if (reg_addr == `GPC_OFS_P61)
			idx = P61;
		else if (reg_addr == `GPC_OFS_P62)
			idx = P62;
		else if (reg_addr == `GPC_OFS_P63)
			idx = P63;
		else
			hit = 1'b0;
	end

	// Register writes; reserved bits never store
	always @(posedge clk) begin
		if (sys_rst) begin
			for (i = 0; i < NPIN; i = i + 1)
				cfg_q[i] <= rst_val(i[3:0]);
			cmb1_q <= `GPC_RST_CMB;
			cmb2_q <= `GPC_RST_CMB;
			data_q <= `GPC_RST_DATA;
		end else if (reg_wr) begin
			if (hit) begin
				cfg_q[idx] <= reg_wdata & wr_mask(idx); // [RQ19]
			end else if (reg_addr == `GPC_OFS_CMB1) begin
				cmb1_q <= reg_wdata & `GPC_MASK_CMB; // [RQ19]
			end else if (reg_addr == `GPC_OFS_CMB2) begin
				cmb2_q <= reg_wdata & `GPC_MASK_CMB; // [RQ19]
			end else if (reg_addr == `GPC_OFS_DATA_LO) begin
				data_q[7:0] <= reg_wdata;
			end else if (reg_addr == `GPC_OFS_DATA_HI) begin
				data_q[10:8] <= reg_wdata[2:0];
			end
		end
	end

	// Read mux; data registers show live pin levels, unmapped reads zero
	always @* begin
		rdata_d = 8'h00;
		if (hit)
			rdata_d = cfg_q[idx];
		else if (reg_addr == `GPC_OFS_CMB1)
			rdata_d = cmb1_q;
		else if (reg_addr == `GPC_OFS_CMB2)
			rdata_d = cmb2_q;
		else if (reg_addr == `GPC_OFS_DATA_LO)
			rdata_d = level[7:0];
		else if (reg_addr == `GPC_OFS_DATA_HI)
			rdata_d = {5'h00, level[10:8]};
	end

	// Read data valid in the cycle after the strobe only
	always @(posedge clk) begin
		if (sys_rst)
			reg_rdata_q <= 8'h00;
		else if (reg_rd)
			reg_rdata_q <= rdata_d;
		else
			reg_rdata_q <= 8'h00;
	end

	// Function decode per pin: plain mode, alternate drive and value
	always @* begin
		gpio_m = 11'h000;
		alt_drv = 11'h000;
		alt_val = 11'h7ff;
		// Group 1: single select bit, alternate is always an output
		gpio_m[P15] = ~cfg_q[P15][`GPC_BIT_FN1]; // [RQ6]
		alt_drv[P15] = 1'b1;
		alt_val[P15] = infrared_transmit_port2; // [RQ6]
		gpio_m[P16] = ~cfg_q[P16][`GPC_BIT_FN1]; // [RQ7]
		alt_drv[P16] = 1'b1;
		alt_val[P16] = floppy_motor_on_drive1_n; // [RQ7]
		gpio_m[P17] = ~cfg_q[P17][`GPC_BIT_FN1]; // [RQ8]
		alt_drv[P17] = 1'b1;
		alt_val[P17] = floppy_drive_select1_n; // [RQ8]
		// Pin 5.0: clock and irq are inputs, reserved code floats
		gpio_m[P50] = fsel(cfg_q[P50]) == `GPC_FN_10; // [RQ9]
		// Pin 5.2 has its own encoding, plain mode is code 01
		case (fsel(cfg_q[P52]))
			`GPC_FN_00: begin
				alt_drv[P52] = 1'b1;
				alt_val[P52] = drive_density_out1; // [RQ10]
			end
			`GPC_FN_01: gpio_m[P52] = 1'b1; // [RQ10]
			`GPC_FN_11: begin
				alt_drv[P52] = 1'b1;
				alt_val[P52] = system_mgmt_interrupt_n; // [RQ10]
			end
			default: alt_drv[P52] = 1'b0;
		endcase
		// Pins 5.3 and 5.4: boot ROM strobes on code 00
		gpio_m[P53] = fsel(cfg_q[P53]) == `GPC_FN_10; // [RQ11]
		alt_drv[P53] = fsel(cfg_q[P53]) == `GPC_FN_00; // [RQ11]
		alt_val[P53] = boot_rom_chip_select_n;
		gpio_m[P54] = fsel(cfg_q[P54]) == `GPC_FN_10; // [RQ12]
		alt_drv[P54] = fsel(cfg_q[P54]) == `GPC_FN_00; // [RQ12]
		alt_val[P54] = boot_rom_output_enable_n;
		// Group 6: ROM data turns around with the ROM cycle
		for (j = P60; j <= P63; j = j + 1) begin
			gpio_m[j] = fsel(cfg_q[j]) == `GPC_FN_10;
			alt_drv[j] = (fsel(cfg_q[j]) == `GPC_FN_00) & rom_data_drive;
			alt_val[j] = rom_data_out[j-P60];
		end
		// Code 11 outputs of group 6; ring on 6.2 is an input
		if (fsel(cfg_q[P60]) == `GPC_FN_11) begin
			alt_drv[P60] = 1'b1;
			alt_val[P60] = system_mgmt_interrupt_n; // [RQ13]
		end
		if (fsel(cfg_q[P61]) == `GPC_FN_11) begin
			alt_drv[P61] = 1'b1;
			alt_val[P61] = led_drive; // [RQ14]
		end
		if (fsel(cfg_q[P63]) == `GPC_FN_11) begin
			alt_drv[P63] = 1'b1;
			alt_val[P63] = watchdog_timeout_out; // [RQ16]
		end
	end

	// One pad driver per pin
	genvar g;
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : pin
			gpc_pin_cell u_cell (
				.clk(clk),
				.sys_rst(sys_rst),
				.cfg(cfg_q[g]),
				.gpio_mode(gpio_m[g]),
				.gpio_val(data_q[g]),
				.alt_drv(alt_drv[g]),
				.alt_val(alt_val[g]),
				.pad_sync(sync2_q[g]),
				.pad_out_q(pad_out[g]),
				.pad_oe_n_q(pad_oe_n[g]),
				.level(level[g])
			);
			assign dir_in[g] = cfg_q[g][`GPC_BIT_DIR]; // [RQ1]
		end
	endgenerate

	// Group enables: bit 2 for group 1, bit 5 for groups 5 and 6
	always @* begin
		en1 = 11'h000;
		en2 = 11'h000;
		for (m = 0; m < NPIN; m = m + 1) begin
			if (m <= P17)
				en1[m] = cfg_q[m][`GPC_BIT_EN1]; // [RQ4]
			else
				en2[m] = cfg_q[m][`GPC_BIT_EN2]; // [RQ5]
		end
	end

	// Only input pins at an active level raise a combined interrupt
	assign cmb1_raw = |(en1 & level & gpio_m & dir_in); // [RQ20]
	assign cmb2_raw = |(en2 & level & gpio_m & dir_in); // [RQ20]

	// Filters always run so that switching them in is glitch free
	gpc_debounce #(
		.CYCLES(DEBOUNCE_CYC),
		.CW(32)
	) u_flt1 (
		.clk(clk),
		.sys_rst(sys_rst),
		.din(cmb1_raw),
		.dout_q(cmb1_flt)
	);
	gpc_debounce #(
		.CYCLES(DEBOUNCE_CYC),
		.CW(32)
	) u_flt2 (
		.clk(clk),
		.sys_rst(sys_rst),
		.din(cmb2_raw),
		.dout_q(cmb2_flt)
	);

	assign cmb1 = cmb1_q[`GPC_BIT_FILT] ? cmb1_flt : cmb1_raw; // [RQ18]
	assign cmb2 = cmb2_q[`GPC_BIT_FILT] ? cmb2_flt : cmb2_raw; // [RQ18]

	// Host lines: combined routes plus pins in their irq function
	always @* begin
		irq_d = route(cmb1_q[`GPC_MAP_MSB:`GPC_MAP_LSB]) & {16{cmb1}};
		irq_d = irq_d
			| (route(cmb2_q[`GPC_MAP_MSB:`GPC_MAP_LSB]) & {16{cmb2}});
		if (fsel(cfg_q[P50]) == `GPC_FN_01)
			irq_d[`GPC_IRQ_P50] = irq_d[`GPC_IRQ_P50] | level[P50]; // [RQ9]
		if (fsel(cfg_q[P52]) == `GPC_FN_10)
			irq_d[`GPC_IRQ_P52] = irq_d[`GPC_IRQ_P52] | level[P52]; // [RQ10]
		if (fsel(cfg_q[P53]) == `GPC_FN_01)
			irq_d[`GPC_IRQ_P53] = irq_d[`GPC_IRQ_P53] | level[P53]; // [RQ11]
		if (fsel(cfg_q[P54]) == `GPC_FN_01)
			irq_d[`GPC_IRQ_P54] = irq_d[`GPC_IRQ_P54] | level[P54]; // [RQ12]
		if (fsel(cfg_q[P60]) == `GPC_FN_01)
			irq_d[`GPC_IRQ_P60] = irq_d[`GPC_IRQ_P60] | level[P60]; // [RQ13]
		if (fsel(cfg_q[P61]) == `GPC_FN_01)
			irq_d[`GPC_IRQ_P61] = irq_d[`GPC_IRQ_P61] | level[P61]; // [RQ14]
		if (fsel(cfg_q[P62]) == `GPC_FN_01)
			irq_d[`GPC_IRQ_P62] = irq_d[`GPC_IRQ_P62] | level[P62]; // [RQ15]
		if (fsel(cfg_q[P63]) == `GPC_FN_01)
			irq_d[`GPC_IRQ_P63] = irq_d[`GPC_IRQ_P63] | level[P63]; // [RQ16]
	end

	// Registered alternate inputs; unselected ones sit at idle, except ROM data, which always follows pads 6.0-6.3
	always @(posedge clk) begin
		if (sys_rst) begin
			host_irq_q <= 16'h0000;
			pci_clock_q <= 1'b0;
			ring_indicate_n_q <= 1'b1;
			rom_data_in_q <= 4'h0;
			edge_int_q <= 2'h0;
		end else begin
			host_irq_q <= irq_d;
			// Sampled clock only; fine for presence, not for timing
			pci_clock_q <= (fsel(cfg_q[P50]) == `GPC_FN_00)
				& sync2_q[P50]; // [RQ9]
			ring_indicate_n_q <= (fsel(cfg_q[P62]) != `GPC_FN_11)
				| sync2_q[P62]; // [RQ15]
			rom_data_in_q <= sync2_q[P63:P60]; // [RQ13]
			// Either edge gives a one-cycle pulse
			edge_int_q[0] <= (fsel(cfg_q[P53]) == `GPC_FN_11)
				& (sync2_q[P53] ^ prev_q[P53]); // [RQ11]
			edge_int_q[1] <= (fsel(cfg_q[P54]) == `GPC_FN_11)
				& (sync2_q[P54] ^ prev_q[P54]); // [RQ12]
		end
	end
endmodule // gpc_pin_config_mux

// ### tb/gpc_board_model.sv
// Board side of the pads: external drivers and pull-ups
`timescale 1ns/1ps
module gpc_board_model (
	input wire [10:0] pad_out,
	input wire [10:0] pad_oe_n,
	input wire [10:0] ext_val,
	input wire [10:0] ext_drv,
	output wire [10:0] pad_in
);
	// Block wins where it drives; a released pad follows the board driver, else the pull-up
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ~ext_drv)
		| (pad_oe_n & ext_drv & ext_val);
endmodule // gpc_board_model

// ### tb/gpc_pin_config_mux_properties.sv
// Timing checker for pads, interrupts and the register port
`timescale 1ns/1ps
module gpc_pin_config_mux_properties (
	input wire clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_q,
	input wire [10:0] pad_out,
	input wire [10:0] pad_oe_n,
	input wire infrared_transmit_port2,
	input wire boot_rom_output_enable_n,
	input wire [1:0] edge_int_q,
	input wire [15:0] host_irq_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Pin 1.5 write strobe
	wire w15 = reg_wr && reg_addr == 8'he5;
	property p_dir_in;
		w15 && reg_wdata[0] && !reg_wdata[3] |=> ##1 pad_oe_n[0];
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("input pin driven");
	property p_dir_out;
		w15 && reg_wdata[7:0] == 8'h00 |=> ##1 !pad_oe_n[0];
	endproperty
	a_dir_out: assert property (p_dir_out) else $error("output not driven");
	// Open drain never drives high, held over several cycles
	property p_od;
		w15 && reg_wdata[7] && !reg_wdata[3] |=> ##1 (pad_oe_n[0] || !pad_out[0]) [*3];
	endproperty
	a_od: assert property (p_od) else $error("open drain drove high");
	property p_ir;
		w15 && reg_wdata[3] && !reg_wdata[7] |=> ##1
			(!pad_oe_n[0] && pad_out[0] == $past(infrared_transmit_port2));
	endproperty
	a_ir: assert property (p_ir) else $error("infrared not on pin");
	// Pin 5.0 drives only in plain output mode
	property p_p50;
		reg_wr && reg_addr == 8'hc8 && !(reg_wdata[4:3] == 2'b10 && !reg_wdata[0])
			|=> ##1 pad_oe_n[3];
	endproperty
	a_p50: assert property (p_p50) else $error("pin 5.0 driven");
	property p_romoe;
		reg_wr && reg_addr == 8'hcc && reg_wdata[4:3] == 2'b00 && !reg_wdata[7]
			|-> ##2 (!pad_oe_n[6] && pad_out[6] == $past(boot_rom_output_enable_n));
	endproperty
	a_romoe: assert property (p_romoe) else $error("rom enable not on pin");
	// Edge interrupt of pin 5.3 is a single-cycle pulse
	property p_edge;
		$rose(edge_int_q[0]) |=> $fell(edge_int_q[0]);
	endproperty
	a_edge: assert property (p_edge) else $error("edge pulse too long");
	property p_rsv1;
		reg_rd && reg_addr inside {8'he5, 8'he6, 8'he7} |=> reg_rdata_q[6:4] == 3'h0;
	endproperty
	a_rsv1: assert property (p_rsv1) else $error("group 1 reserved set");
	property p_rsv56;
		reg_rd && reg_addr >= 8'hc8 && reg_addr <= 8'hd3
			|=> !reg_rdata_q[6] && !reg_rdata_q[2];
	endproperty
	a_rsv56: assert property (p_rsv56) else $error("group 5/6 reserved set");
	// Map codes 0 and 2 lead nowhere, so those lines stay low
	property p_map;
		!host_irq_q[0] && !host_irq_q[2];
	endproperty
	a_map: assert property (p_map) else $error("disabled irq line raised");
	c_ir: cover property (w15 && reg_wdata == 8'h08);
	c_cmb: cover property (host_irq_q[9]);
	c_edge: cover property (edge_int_q[1]);
endmodule // gpc_pin_config_mux_properties

// ### tb/gpc_pin_config_mux_tb.sv
// Self-checking bench for the pin configuration block
`timescale 1ns/1ps
module gpc_pin_config_mux_tb;
	reg clk, sys_rst, reg_wr, reg_rd, rd_seen, rdd;
	reg [7:0] reg_addr, reg_wdata;
	reg [10:0] ext_val, ext_drv;
	reg [8:0] alt;
	reg [3:0] rdo;
	reg [31:0] seed;
	reg [15:0] e;
	wire [7:0] reg_rdata_q;
	wire [10:0] pad_in, pad_out, pad_oe_n;
	wire [1:0] edge_q;
	wire pci, ring_n;
	wire [3:0] romin;
	wire [15:0] irq;
	integer error_cnt, cmp_count, i, k;
	reg [7:0] exp_q[$];
	// Offsets in pad order, irq numbers of pads 3..10, alt cases
	localparam [87:0] OFS = {8'hd3, 8'hd2, 8'hd1, 8'hd0, 8'hcc, 8'hcb,
		8'hca, 8'hc8, 8'he7, 8'he6, 8'he5};
	localparam [31:0] IRQN = {4'h5, 4'h4, 4'h3, 4'h1, 4'hc, 4'hb, 4'h8, 4'he};
	localparam [159:0] ALT = {16'ha188, 16'h8187, 16'h7186, 16'h4186,
		16'h6005, 16'h5004, 16'h4003, 16'h2082, 16'h1081, 16'h0080};
	gpc_pin_config_mux #(.DEBOUNCE_CYC(4)) dut_u (.clk, .sys_rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .pad_in, .pad_out,
		.pad_oe_n, .infrared_transmit_port2(alt[0]),
		.floppy_motor_on_drive1_n(alt[1]), .floppy_drive_select1_n(alt[2]),
		.drive_density_out1(alt[3]), .boot_rom_chip_select_n(alt[4]),
		.boot_rom_output_enable_n(alt[5]), .system_mgmt_interrupt_n(alt[6]),
		.led_drive(alt[7]), .watchdog_timeout_out(alt[8]),
		.rom_data_out(rdo), .rom_data_drive(rdd), .pci_clock_q(pci),
		.ring_indicate_n_q(ring_n), .rom_data_in_q(romin),
		.edge_int_q(edge_q), .host_irq_q(irq));
	gpc_board_model brd_u (.pad_out, .pad_oe_n, .ext_val, .ext_drv, .pad_in);
	function [31:0] xs(input [31:0] s);
		begin
			xs = s ^ (s << 13);
			xs = xs ^ (xs >> 17);
			xs = xs ^ (xs << 5);
		end
	endfunction
	task automatic check(input string nm, input [15:0] s, input [15:0] x);
		begin
			cmp_count = cmp_count + 1;
			if (s !== x) begin
				error_cnt = error_cnt + 1;
				$display("[FAIL] %0s exp %h seen %h", nm, x, s);
			end
		end
	endtask
	task conclude;
		begin
			$display("errors %0d compares %0d", error_cnt, cmp_count);
			if (error_cnt == 0 && cmp_count > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// Bus cycles; each ends with one idle edge so strobes never clash
	task wr(input [7:0] a, input [7:0] d);
		begin
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk);
			reg_wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd(input [7:0] a, input [7:0] x);
		begin
			reg_rd <= 1'b1;
			reg_addr <= a;
			exp_q.push_back(x);
			@(posedge clk);
			reg_rd <= 1'b0;
			@(posedge clk);
		end
	endtask
	// Write then read back with no gap
	task wr_rd(input [7:0] a, input [7:0] d, input [7:0] x);
		begin
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_rd <= 1'b1;
			exp_q.push_back(x);
			@(posedge clk);
			reg_rd <= 1'b0;
			@(posedge clk);
		end
	endtask
	// Configure, let pads settle, then look at the wire and enable
	task cfgchk(input [7:0] a, input [7:0] d, input [3:0] p, input [1:0] x);
		begin
			wr(a, d);
			repeat (4) @(posedge clk);
			check("pad", {pad_in[p], pad_oe_n[p]}, x);
		end
	endtask
	// Bounded wait for an edge pulse; a timeout ends the run
	task wait_edge(input integer b);
		integer n;
		begin
			n = 0;
			do begin
				@(posedge clk);
				n = n + 1;
			end while (edge_q[b] !== 1'b1 && n < 20);
			check("edge", edge_q[b], 1'b1);
			if (edge_q[b] !== 1'b1)
				conclude;
		end
	endtask
	// Read answers arrive one cycle after the strobe
	always @(posedge clk) begin
		if (rd_seen)
			check("rdata", reg_rdata_q, exp_q.pop_front());
		rd_seen <= reg_rd;
	end
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{sys_rst, reg_wr, reg_rd, rd_seen, rdd} = 5'h10;
		{reg_addr, reg_wdata, ext_val, ext_drv, alt, rdo} = 0;
		{error_cnt, cmp_count} = 0;
		seed = 32'h90737ee9;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		// Reset values, an unmapped index, then random write-backs
		for (i = 0; i < 11; i = i + 1)
			rd(OFS[8*i+:8], i == 4 ? 8'h09 : 8'h01);
		rd(8'hc9, 8'h00);
		for (i = 0; i < 11; i = i + 1) begin
			seed = xs(seed);
			wr_rd(OFS[8*i+:8], seed[7:0], seed[7:0] & (i < 3 ? 8'h8f : 8'hbb));
		end
		// Second reset in mid-run clears the random setup
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		// Pin 1.5 direction, polarity and driver type
		wr(8'hf8, 8'h01);
		cfgchk(8'he5, 8'h01, 0, 2'b11);
		cfgchk(8'he5, 8'h00, 0, 2'b10);
		cfgchk(8'he5, 8'h02, 0, 2'b00);
		cfgchk(8'he5, 8'h80, 0, 2'b11);
		wr(8'hf8, 8'h00);
		cfgchk(8'he5, 8'h80, 0, 2'b00);
		// Alternate outputs with random sources, twice
		repeat (2) begin
			seed = xs(seed);
			alt <= seed[8:0];
			rdo <= seed[12:9];
			rdd <= 1'b1;
			@(posedge clk);
			for (k = 0; k < 10; k = k + 1) begin
				e = ALT[16*k+:16];
				cfgchk(OFS[8*e[15:12]+:8], e[11:4], e[15:12],
					{alt[e[3:0]], 1'b0});
			end
			for (k = 0; k < 4; k = k + 1)
				cfgchk(OFS[8*(7+k)+:8], 8'h00, 7 + k, {rdo[k], 1'b0});
		end
		// Pin interrupt functions follow the pad level
		ext_drv <= 11'h7f8;
		for (k = 3; k < 11; k = k + 1) begin
			ext_val[k] <= 1'b1;
			wr(OFS[8*k+:8], k == 4 ? 8'h11 : 8'h09);
			repeat (4) @(posedge clk);
			check("irq", irq[IRQN[4*(k-3)+:4]], 1'b1);
			ext_val[k] <= 1'b0;
			repeat (4) @(posedge clk);
			check("irq", irq[IRQN[4*(k-3)+:4]], 1'b0);
		end
		// Pin inputs toward other blocks: clock, ring and ROM data
		seed = xs(seed);
		ext_val[10:7] <= seed[3:0];
		ext_val[3] <= 1'b1;
		wr(8'hc8, 8'h01);
		wr(8'hd2, 8'h19);
		repeat (4) @(posedge clk);
		check("romin", romin, seed[3:0]);
		check("pci", pci, 1'b1);
		check("ring", ring_n, seed[2]);
		ext_val[10:3] <= 8'h00;
		wr(8'hd2, 8'h11);
		repeat (4) @(posedge clk);
		check("ring", ring_n, 1'b1);
		// Combined interrupt 2 from pin 6.0: route, polarity, disable
		ext_val[7] <= 1'b1;
		wr(8'hd0, 8'h31);
		wr(8'hef, 8'h90);
		repeat (4) @(posedge clk);
		check("cmb2", irq[9], 1'b1);
		wr(8'hd0, 8'h33);
		repeat (4) @(posedge clk);
		check("cmb2", irq[9], 1'b0);
		wr(8'hd0, 8'h31);
		wr(8'hef, 8'h00);
		repeat (4) @(posedge clk);
		check("cmb2", irq, 16'h0000);
		// Filter hides a short glitch and passes a steady level
		ext_val[7] <= 1'b0;
		wr(8'hef, 8'h98);
		repeat (12) @(posedge clk);
		ext_val[7] <= 1'b1;
		repeat (2) @(posedge clk);
		ext_val[7] <= 1'b0;
		repeat (8) begin
			@(posedge clk);
			check("filt", irq[9], 1'b0);
		end
		ext_val[7] <= 1'b1;
		repeat (12) @(posedge clk);
		check("filt", irq[9], 1'b1);
		// Combined interrupt 1 from pin 1.5, then its enable cleared
		ext_drv[0] <= 1'b1;
		ext_val[0] <= 1'b1;
		wr(8'hf0, 8'h70);
		wr(8'he5, 8'h05);
		repeat (4) @(posedge clk);
		check("cmb1", irq[7], 1'b1);
		wr(8'he5, 8'h01);
		repeat (4) @(posedge clk);
		check("cmb1", irq[7], 1'b0);
		// Either-edge interrupts on pins 5.3 and 5.4
		for (k = 0; k < 2; k = k + 1) begin
			wr(OFS[8*(5+k)+:8], 8'h19);
			repeat (2) begin
				ext_val[5+k] <= ~ext_val[5+k];
				wait_edge(k);
			end
		end
		repeat (4) @(posedge clk);
		conclude;
	end
endmodule // gpc_pin_config_mux_tb
bind gpc_pin_config_mux gpc_pin_config_mux_properties chk_u (.clk, .sys_rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .pad_out,
	.pad_oe_n, .infrared_transmit_port2, .boot_rom_output_enable_n,
	.edge_int_q, .host_irq_q);
